// File: hdl/psf_flags.sv
module psf_flags #(
   parameter int WORD_W = psf_pkg::PSF_WORD_W
) (
   input  wire logic                  i_core_clk,    // Core clock, 40 MHz.
   input  wire logic                  i_rst_n,       // Synchronous reset, active low.
   input  wire logic [3:0]            i_addr,        // Register byte address.
   input  wire logic [31:0]           i_wdata,       // Register write data.
   input  wire logic                  i_wr,          // Write strobe.
   input  wire logic                  i_rd,          // Read strobe.
   output logic      [31:0]           o_rdata,       // Read data, one cycle after strobe.
   input  wire psf_pkg::psf_op_t      i_op,          // Arithmetic or logic result to flag.
   input  wire psf_pkg::psf_cmd_t     i_cmd,         // Flag control command.
   input  wire logic [15:0]           i_cmd_data,    // Data for flag load commands.
   input  wire logic                  i_instr_done,  // Instruction boundary pulse.
   input  wire logic                  i_step_entry,  // Single-step interrupt entry pulse.
   input  wire logic                  i_irq_req,     // Maskable interrupt request level.
   output logic      [15:0]           o_flags,       // Current flags word.
   output logic                       o_step_trap,   // Single-step trap request pulse.
   output logic                       o_irq_accept,  // Maskable interrupt accepted pulse.
   output logic                       o_index_dec,   // String index steps down when high.
   output logic                       o_irq          // Event interrupt, level.
);
   import psf_pkg::*;

   if (WORD_W != 16) begin : g_check
      $error("psf_flags serves only a 16-bit flags word");
   end

   psf_state_t q_r;
   psf_state_t q_nxt;
   psf_res_t   alu;

   // Carry, auxiliary carry and overflow for byte or word add and subtract.
   function automatic psf_res_t psf_alu(input psf_op_t op);
      logic [16:0] s16;
      logic [8:0]  s8;
      logic [4:0]  s4;
      logic        sa;
      logic        sb;
      logic        sr;
      psf_res_t    r;
      s16 = 17'h0_0000;
      s8  = 9'h000;
      s4  = 5'h00;
      r   = '0;
      if (op.kind == PSF_K_ADD) begin
         s16 = {1'b0, op.a} + {1'b0, op.b} + {16'h0000, op.cin};
         s8  = {1'b0, op.a[7:0]} + {1'b0, op.b[7:0]} + {8'h00, op.cin};
         s4  = {1'b0, op.a[3:0]} + {1'b0, op.b[3:0]} + {4'h0, op.cin};
      end else if (op.kind == PSF_K_SUB) begin
         // The extra top bit wraps to one exactly when a borrow is needed.
         s16 = {1'b0, op.a} - {1'b0, op.b} - {16'h0000, op.cin};
         s8  = {1'b0, op.a[7:0]} - {1'b0, op.b[7:0]} - {8'h00, op.cin};
         s4  = {1'b0, op.a[3:0]} - {1'b0, op.b[3:0]} - {4'h0, op.cin};
      end
      if (op.kind == PSF_K_LOGIC) begin
         r.res = op.logic_res;
      end else begin
         r.res   = s16[15:0];
         r.carry = op.is_byte ? s8[8] : s16[16];
         r.aux   = s4[4];
         sa = op.is_byte ? op.a[7] : op.a[15];
         sb = op.is_byte ? op.b[7] : op.b[15];
         sr = op.is_byte ? s8[7] : s16[15];
         if (op.kind == PSF_K_ADD) begin
            r.ovf = (sa == sb) && (sr != sa);
         end else begin
            r.ovf = (sa != sb) && (sr != sa);
         end
      end
      return r;
   endfunction

   // Keeps the function bits live and forces the unused ones.
   function automatic logic [15:0] psf_clean(input logic [15:0] v);
      return (v & PSF_LIVE_MASK) | (PSF_FIXED_VAL & ~PSF_LIVE_MASK);
   endfunction

   assign alu = psf_alu(i_op);

   always_comb begin
      logic [7:0] low;
      logic       zero;
      logic       sign;
      logic [2:0] ev_set;
      logic [2:0] ev_clr;
      low    = alu.res[7:0];
      zero   = 1'b0;
      sign   = 1'b0;
      ev_set = 3'h0;
      ev_clr = 3'h0;
      q_nxt  = q_r;
      q_nxt.step_trap = 1'b0;
      q_nxt.irq_acc   = 1'b0;
      q_nxt.rdata     = 32'h0000_0000;

      // Entry clears the step flag first so that a set in the same cycle wins.
      if (i_step_entry) begin
         q_nxt.flags[PSF_B_STEP] = 1'b0;
      end

      if (i_wr && i_addr == PSF_OFS_FLAGS) begin
         q_nxt.flags = psf_clean(i_wdata[15:0]);
      end

      case (i_cmd)
         PSF_C_STC: q_nxt.flags[PSF_B_CARRY] = 1'b1;
         PSF_C_CLC: q_nxt.flags[PSF_B_CARRY] = 1'b0;
         PSF_C_CMC: q_nxt.flags[PSF_B_CARRY] = ~q_nxt.flags[PSF_B_CARRY];
         PSF_C_STD: q_nxt.flags[PSF_B_DIR] = 1'b1;
         PSF_C_CLD: q_nxt.flags[PSF_B_DIR] = 1'b0;
         PSF_C_STI: q_nxt.flags[PSF_B_IEN] = 1'b1;
         PSF_C_CLI: q_nxt.flags[PSF_B_IEN] = 1'b0;
         PSF_C_LOAD_WORD: begin
            q_nxt.flags = psf_clean(i_cmd_data);
         end
         PSF_C_LOAD_LOW: begin
            q_nxt.flags = psf_clean({q_nxt.flags[15:8], i_cmd_data[7:0]});
         end
         default: begin
         end
      endcase

      // Results update all six result flags, in the place they are kept.
      if (i_op.valid && i_op.kind != PSF_K_NONE) begin
         zero = i_op.is_byte ? (low == 8'h00) : (alu.res == 16'h0000);
         sign = i_op.is_byte ? alu.res[7] : alu.res[15];
         q_nxt.flags[PSF_B_CARRY] = alu.carry;
         q_nxt.flags[PSF_B_PAR]   = ~^low;
         q_nxt.flags[PSF_B_AUX]   = alu.aux;
         q_nxt.flags[PSF_B_ZERO]  = zero;
         q_nxt.flags[PSF_B_SIGN]  = sign;
         q_nxt.flags[PSF_B_OVF]   = alu.ovf;
         ev_set[PSF_E_OVF]        = alu.ovf;
      end

      // The armed bit delays the trap by one instruction, so the instruction
      // that sets the step flag is not itself trapped.
      if (i_instr_done) begin
         q_nxt.step_trap = q_r.armed;
         q_nxt.armed     = q_r.flags[PSF_B_STEP] & ~i_step_entry;
         q_nxt.irq_acc   = i_irq_req & q_r.flags[PSF_B_IEN];
      end
      if (i_step_entry) begin
         q_nxt.armed = 1'b0;
      end
      ev_set[PSF_E_STEP] = q_nxt.step_trap;
      ev_set[PSF_E_IRQ]  = q_nxt.irq_acc;

      if (i_wr && i_addr == PSF_OFS_EVT) begin
         ev_clr = i_wdata[2:0];
      end
      if (i_wr && i_addr == PSF_OFS_MASK) begin
         q_nxt.mask = i_wdata[2:0];
      end
      // A new event beats a clear written in the same cycle.
      q_nxt.evt = (q_r.evt & ~ev_clr) | ev_set;
      q_nxt.irq = |(q_nxt.evt & q_nxt.mask);

      if (i_rd) begin
         case (i_addr)
            PSF_OFS_FLAGS: q_nxt.rdata = {16'h0000, q_r.flags};
            PSF_OFS_EVT:   q_nxt.rdata = {29'h0000_0000, q_r.evt};
            PSF_OFS_MASK:  q_nxt.rdata = {29'h0000_0000, q_r.mask};
            default:       q_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         q_r <= PSF_STATE_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign o_rdata      = q_r.rdata;
   assign o_flags      = q_r.flags;
   assign o_step_trap  = q_r.step_trap;
   assign o_irq_accept = q_r.irq_acc;
   assign o_index_dec  = q_r.flags[PSF_B_DIR];
   assign o_irq        = q_r.irq;
endmodule

// File: pkg/psf_pkg.sv
package psf_pkg;

   localparam int PSF_WORD_W = 16;
   localparam int PSF_ADDR_W = 4;
   localparam int PSF_DATA_W = 32;

   // Register offsets on the software port.
   localparam logic [3:0] PSF_OFS_FLAGS = 4'h0;
   localparam logic [3:0] PSF_OFS_EVT   = 4'h4;
   localparam logic [3:0] PSF_OFS_MASK  = 4'h8;

   // Flag bit positions within the flags word.
   localparam int PSF_B_CARRY = 0;
   localparam int PSF_B_PAR   = 2;
   localparam int PSF_B_AUX   = 4;
   localparam int PSF_B_ZERO  = 6;
   localparam int PSF_B_SIGN  = 7;
   localparam int PSF_B_STEP  = 8;
   localparam int PSF_B_IEN   = 9;
   localparam int PSF_B_DIR   = 10;
   localparam int PSF_B_OVF   = 11;

   localparam logic [15:0] PSF_LIVE_MASK = 16'h0FD5;
   localparam logic [15:0] PSF_FIXED_VAL = 16'h0000;
   localparam logic [15:0] PSF_FLAGS_RST = 16'h0000;

   // Event status bits.
   localparam int         PSF_EVT_W    = 3;
   localparam int         PSF_E_STEP   = 0;
   localparam int         PSF_E_IRQ    = 1;
   localparam int         PSF_E_OVF    = 2;
   localparam logic [2:0] PSF_EVT_RST  = 3'h0;
   localparam logic [2:0] PSF_MASK_RST = 3'h0;

   typedef enum logic [1:0] {PSF_K_NONE, PSF_K_ADD, PSF_K_SUB, PSF_K_LOGIC} psf_kind_t;

   typedef enum logic [3:0] {
      PSF_C_NOP, PSF_C_STC, PSF_C_CLC, PSF_C_CMC, PSF_C_STD, PSF_C_CLD,
      PSF_C_STI, PSF_C_CLI, PSF_C_LOAD_WORD, PSF_C_LOAD_LOW
   } psf_cmd_t;

   typedef struct packed {
      logic        valid;
      psf_kind_t   kind;
      logic        is_byte;
      logic        cin;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] logic_res;
   } psf_op_t;

   typedef struct packed {
      logic        carry;
      logic        aux;
      logic        ovf;
      logic [15:0] res;
   } psf_res_t;

   typedef struct packed {
      logic [15:0] flags;
      logic        armed;
      logic        step_trap;
      logic        irq_acc;
      logic [2:0]  evt;
      logic [2:0]  mask;
      logic        irq;
      logic [31:0] rdata;
   } psf_state_t;

   localparam psf_state_t PSF_STATE_RST = '{
      flags: PSF_FLAGS_RST, armed: 1'b0, step_trap: 1'b0, irq_acc: 1'b0,
      evt: PSF_EVT_RST, mask: PSF_MASK_RST, irq: 1'b0, rdata: 32'h0000_0000
   };
endpackage

// File: dv/psf_dp_model.sv
module psf_dp_model #(
   parameter int DLY = 2  // Handler entry comes DLY + 1 cycles after the trap request.
) (
   input  wire logic i_core_clk,   // Core clock.
   input  wire logic i_rst_n,      // Reset, active low.
   input  wire logic i_step_trap,  // Trap request.
   output logic      o_step_entry  // Handler entry pulse.
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r = 0;
   initial o_step_entry = 1'b0;
   // The sequencer drains its current instruction first, so entry lags the request by DLY + 1 cycles.
   always @(posedge i_core_clk) begin
      o_step_entry <= i_rst_n && cnt_r == 1;
      cnt_r <= !i_rst_n ? 0 : i_step_trap ? DLY : (cnt_r > 0 ? cnt_r - 1 : 0);
   end
endmodule

// File: dv/psf_flags_sva.sv
module psf_flags_chk (
   input wire logic              i_core_clk,   // Clock.
   input wire logic              i_rst_n,      // Reset.
   input wire psf_pkg::psf_op_t  i_op,         // Result.
   input wire psf_pkg::psf_cmd_t i_cmd,        // Command.
   input wire logic              i_instr_done, // Boundary.
   input wire logic              i_irq_req,    // Request.
   input wire logic [15:0]       o_flags,      // Flags.
   input wire logic              o_step_trap,  // Trap.
   input wire logic              o_irq_accept  // Accept.
);
   import psf_pkg::*;
   logic        lg;
   logic        aw;
   logic [15:0] lr;
   logic [16:0] sum_w;
   assign lg = i_op.valid && i_op.kind == PSF_K_LOGIC;
   assign aw = i_op.valid && i_op.kind == PSF_K_ADD && !i_op.is_byte;
   assign lr = i_op.logic_res;
   assign sum_w = {1'b0, i_op.a} + {1'b0, i_op.b} + {16'h0000, i_op.cin};
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   fixed_bits_a: assert property ((o_flags & ~PSF_LIVE_MASK) == 16'h0000) else $error("fixed bit set");
   // A byte operation judges zero and sign on the low byte only.
   zero_flag_a: assert property (lg |=> o_flags[6] == ($past(i_op.is_byte) ? ($past(lr[7:0]) == 8'h00)
      : ($past(lr) == 16'h0000))) else $error("zero flag");
   sign_flag_a: assert property (lg |=> o_flags[7] == ($past(i_op.is_byte) ? $past(lr[7]) : $past(lr[15])))
      else $error("sign flag");
   parity_flag_a: assert property (lg |=> o_flags[2] == ~^$past(lr[7:0])) else $error("parity flag");
   add_carry_a: assert property (aw |=> o_flags[0] == $past(sum_w[16])) else $error("carry flag");
   step_pulse_a: assert property (o_step_trap |-> $past(i_instr_done) && !$past(o_step_trap)) else $error("trap");
   irq_accept_a: assert property (o_irq_accept == $past(i_rst_n && i_instr_done && i_irq_req && o_flags[9]))
      else $error("accept");
   dir_set_a: assert property (i_cmd == PSF_C_STD |=> o_flags[10]) else $error("direction flag");
endmodule
bind psf_flags psf_flags_chk u_chk (.i_core_clk, .i_rst_n, .i_op, .i_cmd, .i_instr_done, .i_irq_req, .o_flags,
   .o_step_trap, .o_irq_accept);

// File: dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import psf_pkg::*;
   logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_instr_done = 1'b0, i_irq_req = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_cmd_data = 16'h0000, o_flags;
   logic [31:0] i_wdata = 32'h0, o_rdata, rd_v;
   psf_op_t     i_op = '0;
   psf_cmd_t    i_cmd = PSF_C_NOP;
   logic        i_step_entry, o_step_trap, o_irq_accept, o_index_dec, o_irq;
   int          fail_count = 0, compares = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   psf_flags u_psf_flags (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_op, .i_cmd,
      .i_cmd_data, .i_instr_done, .i_step_entry, .i_irq_req, .o_flags, .o_step_trap, .o_irq_accept,
      .o_index_dec, .o_irq);
   psf_dp_model #(.DLY(2)) u_psf_dp_model (.i_core_clk, .i_rst_n, .i_step_trap(o_step_trap),
      .o_step_entry(i_step_entry));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Read data stands only in the cycle after the strobe, so it is captured there.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr <= w; i_rd <= !w; i_addr <= a; i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0; i_rd <= 1'b0;
      #1 rd_v = o_rdata;
   endtask
   task automatic dp(input psf_op_t p, input psf_cmd_t c, input logic [15:0] d, input logic dn);
      @(posedge i_core_clk);
      i_op <= p; i_cmd <= c; i_cmd_data <= d; i_instr_done <= dn;
      @(posedge i_core_clk);
      i_op <= '0; i_cmd <= PSF_C_NOP; i_instr_done <= 1'b0;
      #1;
   endtask
   task automatic t_regs;
      bus(1'b1, PSF_OFS_FLAGS, 32'h0000_FFFF);
      chk("flags", 32'h0FD5, 32'(o_flags));
      bus(1'b0, PSF_OFS_FLAGS, 32'h0);
      chk("rdata", 32'h0FD5, rd_v);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, rd_v);
      bus(1'b1, PSF_OFS_FLAGS, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_cmds;
      psf_cmd_t    c[10] = '{PSF_C_STC, PSF_C_CMC, PSF_C_CMC, PSF_C_CLC, PSF_C_STD, PSF_C_CLD, PSF_C_STI,
                             PSF_C_CLI, PSF_C_LOAD_WORD, PSF_C_LOAD_LOW};
      logic [15:0] e[10] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0400, 16'h0000, 16'h0200,
                             16'h0000, 16'h0FD5, 16'h0F00};
      for (int i = 0; i < 10; i++) begin
         dp('0, c[i], (i == 8) ? 16'hFFFF : 16'h0000, 1'b0);
         chk("flags", 32'(e[i]), 32'(o_flags));
         chk("index_dec", 32'(e[i][10]), 32'(o_index_dec));
      end
      $display("t_cmds done");
   endtask
   task automatic t_arith;
      psf_op_t     p[5] = '{'{1'b1, PSF_K_ADD, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 16'h0000},
                            '{1'b1, PSF_K_SUB, 1'b0, 1'b0, 16'h0000, 16'h0001, 16'h0000},
                            '{1'b1, PSF_K_SUB, 1'b1, 1'b0, 16'h0080, 16'h0001, 16'h0000},
                            '{1'b1, PSF_K_ADD, 1'b1, 1'b1, 16'h00FF, 16'h0000, 16'h0000},
                            '{1'b1, PSF_K_LOGIC, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h8003}};
      logic [15:0] e[5] = '{16'h0894, 16'h0095, 16'h0810, 16'h0055, 16'h0084};
      for (int i = 0; i < 5; i++) begin
         dp(p[i], PSF_C_NOP, 16'h0000, 1'b0);
         chk("result_flags", 32'(e[i]), 32'(o_flags & 16'h08D5));
      end
      $display("t_arith done");
   endtask
   task automatic t_step;
      dp('0, PSF_C_LOAD_WORD, 16'h0100, 1'b0);
      dp('0, PSF_C_NOP, 16'h0000, 1'b1);
      chk("step_trap", 32'h0, 32'(o_step_trap));
      dp('0, PSF_C_NOP, 16'h0000, 1'b1);
      chk("step_trap", 32'h1, 32'(o_step_trap));
      repeat (5) @(posedge i_core_clk);
      #1 chk("flags", 32'h0, 32'(o_flags));
      bus(1'b0, PSF_OFS_EVT, 32'h0);
      chk("events", 32'h5, rd_v);
      bus(1'b1, PSF_OFS_MASK, 32'h1);
      chk("irq", 32'h1, 32'(o_irq));
      bus(1'b1, PSF_OFS_EVT, 32'h5);
      chk("irq", 32'h0, 32'(o_irq));
      $display("t_step done");
   endtask
   task automatic t_irq;
      @(posedge i_core_clk);
      i_irq_req <= 1'b1;
      dp('0, PSF_C_NOP, 16'h0000, 1'b1);
      chk("irq_accept", 32'h0, 32'(o_irq_accept));
      dp('0, PSF_C_STI, 16'h0000, 1'b0);
      dp('0, PSF_C_NOP, 16'h0000, 1'b1);
      chk("irq_accept", 32'h1, 32'(o_irq_accept));
      @(posedge i_core_clk);
      i_irq_req <= 1'b0;
      bus(1'b0, PSF_OFS_EVT, 32'h0);
      chk("events", 32'h2, rd_v);
      $display("t_irq done");
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_regs(); t_cmds(); t_arith(); t_step(); t_irq();
      wrap_up();
   end
   // The sequence needs about 70 cycles, so this limit only trips on a hang.
   initial begin
      repeat (2000) @(posedge i_core_clk);
      fail_count++;
      wrap_up();
   end
endmodule
